// ===== common/tsm_pkg.sv
// Package for the TDM slot mapping configuration block.
// Assumes a 40 MHz system clock and one serial link clock.
package tsm_pkg;
  // Register byte addresses
  localparam logic [9:0] OFS_GUARD = 10'h000;
  localparam logic [9:0] OFS_PORT = 10'h004;
  localparam logic [9:0] OFS_LEN = 10'h008;
  localparam logic [9:0] OFS_GRP = 10'h00C;
  localparam logic [9:0] OFS_STAT = 10'h010;
  localparam logic [9:0] OFS_SLOT = 10'h100;
  localparam logic [9:0] OFS_SUB = 10'h200;
  localparam logic [1:0] ADDR_PAGE_SLOT = 2'h1;
  localparam logic [1:0] ADDR_PAGE_SUB = 2'h2;
  localparam int SLOT_WORDS = 8;
  localparam int SUB_WORDS = 64;
  // Field positions
  localparam int GUARD_BIT = 0;
  localparam int FMT_LO = 0;
  localparam int E_TXS = 16;
  localparam int E_TXD = 17;
  localparam int E_RXS = 18;
  localparam int E_RXD = 19;
  localparam int E_RXL = 20;
  localparam int FLOAT_BIT = 24;
  localparam int GRP_TXEN = 0;
  localparam int GRP_SUBOFF = 1;
  localparam int LIM_A_LO = 0;
  localparam int LIM_B_LO = 16;
  localparam int LIM_W = 14;
  localparam int CODE_LO = 5;
  localparam int CH_W = 5;
  localparam int BITON = 7;
  localparam int ST_BUSY = 0;
  localparam int ST_LOSS = 1;
  // Codes and reset values
  localparam logic [2:0] CODE_FULL = 3'h4;
  localparam logic [2:0] CODE_SUB = 3'h7;
  localparam logic [1:0] FMT_E1 = 2'h1;
  localparam logic [1:0] SEL_A = 2'h1;
  localparam logic [1:0] SEL_B = 2'h2;
  localparam logic [7:0] LAST_E1 = 8'hFF;
  localparam logic [7:0] LAST_T1 = 8'hBF;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam int XW = 40;
  typedef enum logic [1:0] {K_PORT, K_GRP, K_SLOT, K_SUB} tsm_kind_t;
endpackage

// ===== verilog/tsm_cdc_word.sv
// Toggle handshake carrying one word from the system clock to the link clock.
// Sender must only send while busy_out is low.
`timescale 1ns/10ps
`default_nettype none
module tsm_cdc_word (
  input wire logic clk_a_in,
  input wire logic rst_a_n_in,
  input wire logic send_in,
  input wire logic [tsm_pkg::XW-1:0] data_in,
  output logic busy_out,
  input wire logic clk_b_in,
  input wire logic rst_b_n_in,
  output logic upd_out,
  output logic [tsm_pkg::XW-1:0] data_out
);
  logic req_ff, nxt_req, ack1_ff, ack2_ff;
  logic [tsm_pkg::XW-1:0] hold_ff, nxt_hold;
  logic r1_ff, r2_ff, r3_ff, upd_ff, nxt_upd;
  logic [tsm_pkg::XW-1:0] dat_ff, nxt_dat;

  // Sender side: word held steady until the far side echoes the toggle
  always_comb begin
    nxt_req = req_ff ^ send_in;
    nxt_hold = send_in ? data_in : hold_ff;
  end
  always_ff @(posedge clk_a_in or negedge rst_a_n_in) begin
    if (!rst_a_n_in) begin
      req_ff <= 1'b0;
      hold_ff <= '0;
      ack1_ff <= 1'b0;
      ack2_ff <= 1'b0;
    end else begin
      req_ff <= nxt_req;
      hold_ff <= nxt_hold;
      ack1_ff <= r3_ff;
      ack2_ff <= ack1_ff;
    end
  end
  assign busy_out = req_ff ^ ack2_ff;

  // Receiver side: the held word is stable when the toggle arrives
  always_comb begin
    nxt_upd = r2_ff ^ r3_ff;
    nxt_dat = nxt_upd ? hold_ff : dat_ff;
  end
  always_ff @(posedge clk_b_in or negedge rst_b_n_in) begin
    if (!rst_b_n_in) begin
      r1_ff <= 1'b0;
      r2_ff <= 1'b0;
      r3_ff <= 1'b0;
      upd_ff <= 1'b0;
      dat_ff <= '0;
    end else begin
      r1_ff <= req_ff;
      r2_ff <= r1_ff;
      r3_ff <= r2_ff;
      upd_ff <= nxt_upd;
      dat_ff <= nxt_dat;
    end
  end
  assign upd_out = upd_ff;
  assign data_out = dat_ff;
endmodule // tsm_cdc_word
`default_nettype wire

// ===== verilog/tsm_link_port.sv
// Link-clock side: shadow maps, edge selection, slot walk, tx/rx bit steering.
// Assumes the link clock runs freely; reset is synchronised here.
`timescale 1ns/10ps
`default_nettype none
module tsm_link_port (
  input wire logic clk_link_in,
  input wire logic rst_n_in,
  input wire logic upd_in,
  input wire logic [tsm_pkg::XW-1:0] upd_data_in,
  input wire logic tx_sync_in,
  input wire logic rx_sync_in,
  input wire logic rx_data_in,
  input wire logic rx_loss_in,
  input wire logic tx_chan_bit_in,
  output logic tx_data_out,
  output logic tx_data_oe_out,
  output logic tx_req_out,
  output logic [tsm_pkg::CH_W-1:0] tx_chan_out,
  output logic rx_bit_out,
  output logic rx_valid_out,
  output logic [tsm_pkg::CH_W-1:0] rx_chan_out,
  output logic rx_loss_out
);
  logic rs1_ff, rs2_ff, lrst_n;
  logic [31:0] port_ff, grp_ff, nxt_port, nxt_grp;
  logic [31:0] slot_ff [tsm_pkg::SLOT_WORDS];
  logic [31:0] nxt_slot [tsm_pkg::SLOT_WORDS];
  logic [31:0] sub_ff [tsm_pkg::SUB_WORDS];
  logic [31:0] nxt_sub [tsm_pkg::SUB_WORDS];
  logic [3:0] pin, esel, neg_ff, samp_ff, nxt_samp;
  logic [7:0] cnt_ff [2];
  logic [7:0] nxt_cnt [2];
  logic [7:0] cur [2];
  logic [1:0] prev_ff, nxt_prev;
  logic [5:0] tx_own, rx_own;
  logic txd_ff, nxt_txd, txn_ff, oe_ff, nxt_oe;
  logic req_ff, nxt_req, rxb_ff, rxv_ff, nxt_rxv, loss_ff;
  logic [4:0] txc_ff, rxc_ff;
  logic [tsm_pkg::XW-33:0] hdr;
  logic [5:0] idx;

  // Reset release synchronised to the link clock
  always_ff @(posedge clk_link_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rs1_ff <= 1'b0;
      rs2_ff <= 1'b0;
    end else begin
      rs1_ff <= 1'b1;
      rs2_ff <= rs1_ff;
    end
  end
  assign lrst_n = rs2_ff;

  // Shadow copies, loaded from either host path
  assign hdr = upd_data_in[tsm_pkg::XW-1:32];
  assign idx = hdr[5:0];
  always_comb begin
    nxt_port = port_ff;
    nxt_grp = grp_ff;
    nxt_slot = slot_ff;
    nxt_sub = sub_ff;
    if (upd_in) begin // R13
      unique case (tsm_pkg::tsm_kind_t'(hdr[7:6]))
        tsm_pkg::K_PORT: nxt_port = upd_data_in[31:0];
        tsm_pkg::K_GRP: nxt_grp = upd_data_in[31:0];
        tsm_pkg::K_SLOT: nxt_slot[idx[2:0]] = upd_data_in[31:0];
        tsm_pkg::K_SUB: nxt_sub[idx] = upd_data_in[31:0];
      endcase
    end
  end
  always_ff @(posedge clk_link_in or negedge lrst_n) begin
    if (!lrst_n) begin
      port_ff <= tsm_pkg::RST_WORD;
      grp_ff <= tsm_pkg::RST_WORD;
      slot_ff <= '{default: tsm_pkg::RST_WORD};
      sub_ff <= '{default: tsm_pkg::RST_WORD};
    end else begin
      port_ff <= nxt_port;
      grp_ff <= nxt_grp;
      slot_ff <= nxt_slot;
      sub_ff <= nxt_sub;
    end
  end

  // Falling-edge capture per input; select zero uses it
  assign pin = {rx_loss_in, rx_data_in, rx_sync_in, tx_sync_in};
  assign esel = {port_ff[tsm_pkg::E_RXL], port_ff[tsm_pkg::E_RXD],
                 port_ff[tsm_pkg::E_RXS], port_ff[tsm_pkg::E_TXS]};
  for (genvar g = 0; g < 4; g++) begin : g_edge
    always_ff @(negedge clk_link_in or negedge lrst_n) begin
      if (!lrst_n) neg_ff[g] <= 1'b0;
      else neg_ff[g] <= pin[g];
    end
    assign nxt_samp[g] = esel[g] ? pin[g] : neg_ff[g]; // R03
  end

  // Owner of one bit of the frame: {valid, channel}
  function automatic logic [5:0] owner(input logic [7:0] b);
    logic [31:0] sw, bw;
    logic [7:0] ent, sent;
    logic [2:0] code;
    sw = slot_ff[b[7:5]];
    ent = sw[8*b[4:3] +: 8]; // R06
    code = ent[tsm_pkg::CODE_LO +: 3];
    bw = sub_ff[{b[7:3], b[2]}]; // R10
    sent = bw[8*b[1:0] +: 8];
    owner = 6'h00; // R15
    if (code == tsm_pkg::CODE_FULL) // R08
      owner = {1'b1, ent[tsm_pkg::CH_W-1:0]}; // R07
    else if (code == tsm_pkg::CODE_SUB) begin // R09
      if (grp_ff[tsm_pkg::GRP_SUBOFF] || b[2:0] == 3'h0) // R14 R12
        owner = {1'b1, ent[tsm_pkg::CH_W-1:0]};
      else if (sent[tsm_pkg::BITON]) // R11
        owner = {1'b1, sent[tsm_pkg::CH_W-1:0]};
    end
    return owner;
  endfunction

  // Slot walk: tx on tx sync, rx on rx sync; frame length by format
  always_comb begin
    nxt_prev = {samp_ff[1], samp_ff[0]};
    for (int i = 0; i < 2; i++) begin
      cur[i] = (samp_ff[i] && !prev_ff[i]) ? 8'h00 : cnt_ff[i];
      if (cur[i] == ((port_ff[tsm_pkg::FMT_LO +: 2] == tsm_pkg::FMT_E1) ? // R04
                     tsm_pkg::LAST_E1 : tsm_pkg::LAST_T1))
        nxt_cnt[i] = 8'h00;
      else
        nxt_cnt[i] = cur[i] + 8'h01;
    end
    tx_own = owner(cur[0]);
    rx_own = owner(cur[1]);
    nxt_req = tx_own[5] && grp_ff[tsm_pkg::GRP_TXEN];
    nxt_txd = req_ff ? tx_chan_bit_in : 1'b1;
    // Unmapped slots float unless the float option and the transmit enable are both set
    nxt_oe = grp_ff[tsm_pkg::GRP_TXEN] &&
             (req_ff || port_ff[tsm_pkg::FLOAT_BIT]); // R02
    nxt_rxv = rx_own[5];
  end
  always_ff @(posedge clk_link_in or negedge lrst_n) begin
    if (!lrst_n) begin
      samp_ff <= 4'h0;
      prev_ff <= 2'h0;
      cnt_ff <= '{default: 8'h00};
      req_ff <= 1'b0;
      txc_ff <= 5'h00;
      txd_ff <= 1'b1;
      oe_ff <= 1'b0;
      rxb_ff <= 1'b0;
      rxv_ff <= 1'b0;
      rxc_ff <= 5'h00;
      loss_ff <= 1'b0;
    end else begin
      samp_ff <= nxt_samp;
      prev_ff <= nxt_prev;
      cnt_ff <= nxt_cnt;
      req_ff <= nxt_req;
      txc_ff <= tx_own[4:0];
      txd_ff <= nxt_txd;
      oe_ff <= nxt_oe;
      rxb_ff <= samp_ff[2];
      rxv_ff <= nxt_rxv;
      rxc_ff <= rx_own[4:0];
      loss_ff <= samp_ff[3];
    end
  end

  // Half-cycle copy so tx data can launch on the falling edge
  always_ff @(negedge clk_link_in or negedge lrst_n) begin
    if (!lrst_n) txn_ff <= 1'b1;
    else txn_ff <= txd_ff;
  end
  assign tx_data_out = port_ff[tsm_pkg::E_TXD] ? txd_ff : txn_ff; // R03
  assign tx_data_oe_out = oe_ff;
  assign tx_req_out = req_ff;
  assign tx_chan_out = txc_ff;
  assign rx_bit_out = rxb_ff;
  assign rx_valid_out = rxv_ff;
  assign rx_chan_out = rxc_ff;
  assign rx_loss_out = loss_ff;

  float_unmapped_a: assert property (@(posedge clk_link_in) disable iff (!lrst_n) // R02
    grp_ff[tsm_pkg::GRP_TXEN] && !port_ff[tsm_pkg::FLOAT_BIT] && !req_ff
    |=> !oe_ff) else $error("unmapped slot driven");
  disabled_slot_a: assert property (@(posedge clk_link_in) disable iff (!lrst_n) // R15
    tx_own[5] == 1'b0 |=> !req_ff ##1 !oe_ff || port_ff[tsm_pkg::FLOAT_BIT])
    else $error("disabled slot carried data");
endmodule // tsm_link_port
`default_nettype wire

// ===== verilog/tsm_cfg_top.sv
// Top of the TDM slot mapping configuration block for one channel group.
// Host reaches it by direct register access or by service request;
// the serial side runs on its own link clock.
//
// Behaviour
// R01 - Guard field zero disables protection checking
// R02 - Unmapped slot floats tx data when enabled; code drives it instead when FLOAT_BIT and GRP_TXEN are both set
// R03 - Edge select zero acts on falling edge
// R04 - Format one gives 32-slot E1 frame
// R05 - Two octet-count message length limits
// R06 - Four slot entries per word, byte order
// R07 - Slot entry names the owning channel
// R08 - Code 4 gives whole slot, 64k
// R09 - Code 7 puts slot in bit-slice mode
// R10 - Two bit-slice words per slot
// R11 - Bit entry: enable plus channel number
// R12 - Bit 0 comes from slot entry
// R13 - Direct write and service request both load
// R14 - Bit slicing only when disable is zero
// R15 - Disabled slots carry no data
`timescale 1ns/10ps
`default_nettype none
module tsm_cfg_top (
  input wire logic CLK_SYS_IN,
  input wire logic RESET_N_IN,
  input wire logic REG_WR_IN,
  input wire logic REG_RD_IN,
  input wire logic [9:0] REG_ADDR_IN,
  input wire logic [31:0] REG_WDATA_IN,
  output logic [31:0] REG_RDATA_OUT,
  output logic REG_ACK_OUT,
  input wire logic SVC_REQ_IN,
  input wire logic [9:0] SVC_ADDR_IN,
  input wire logic [31:0] SVC_DATA_IN,
  output logic SVC_ACK_OUT,
  input wire logic MSG_CHECK_IN,
  input wire logic [1:0] MSG_SEL_IN,
  input wire logic [13:0] MSG_LEN_IN,
  output logic MSG_TOO_LONG_OUT,
  input wire logic DMA_OOB_IN,
  output logic PROT_FAULT_OUT,
  input wire logic CLK_LINK_IN,
  input wire logic TX_SYNC_IN,
  input wire logic RX_SYNC_IN,
  input wire logic RX_DATA_IN,
  input wire logic RX_LOSS_IN,
  input wire logic TX_CHAN_BIT_IN,
  output logic TX_DATA_OUT,
  output logic TX_DATA_OE_OUT,
  output logic TX_REQ_OUT,
  output logic [4:0] TX_CHAN_OUT,
  output logic RX_BIT_OUT,
  output logic RX_VALID_OUT,
  output logic [4:0] RX_CHAN_OUT,
  output logic RX_LOSS_OUT
);
  logic [31:0] guard_ff, port_ff, len_ff, grp_ff;
  logic [31:0] nxt_guard, nxt_port, nxt_len, nxt_grp;
  logic [31:0] slot_ff [tsm_pkg::SLOT_WORDS];
  logic [31:0] nxt_slot [tsm_pkg::SLOT_WORDS];
  logic [31:0] sub_ff [tsm_pkg::SUB_WORDS];
  logic [31:0] nxt_sub [tsm_pkg::SUB_WORDS];
  logic [31:0] rdata_ff, nxt_rdata;
  logic ack_ff, nxt_ack, sack_ff, nxt_sack;
  logic long_ff, nxt_long, fault_ff, nxt_fault;
  logic busy, send, take_reg, take_rd, take_svc, wr_go;
  logic [9:0] wa;
  logic [8:0] wkind;
  logic [31:0] wd;
  logic [tsm_pkg::XW-1:0] xdata;
  logic [7:0] xhdr;
  logic loss1_ff, loss2_ff, link_loss;
  logic upd;
  logic [tsm_pkg::XW-1:0] upd_data;
  logic [13:0] lim_a, lim_b;

  // Decode of a word address into its mirrored kind and index
  function automatic logic [8:0] map_kind(input logic [9:0] a);
    map_kind = 9'h000;
    if (a[9:8] == tsm_pkg::ADDR_PAGE_SLOT && a[7:2] < 6'(tsm_pkg::SLOT_WORDS))
      map_kind = {1'b1, tsm_pkg::K_SLOT, 3'h0, a[4:2]};
    else if (a[9:8] == tsm_pkg::ADDR_PAGE_SUB)
      map_kind = {1'b1, tsm_pkg::K_SUB, a[7:2]};
    else if (a == tsm_pkg::OFS_PORT)
      map_kind = {1'b1, tsm_pkg::K_PORT, 6'h00};
    else if (a == tsm_pkg::OFS_GRP)
      map_kind = {1'b1, tsm_pkg::K_GRP, 6'h00};
    return map_kind;
  endfunction

  // Request arbitration: register access first, service requests next;
  // writes wait while the link copy is still catching up
  always_comb begin
    take_rd = REG_RD_IN && !REG_WR_IN && !ack_ff;
    take_reg = REG_WR_IN && !ack_ff && !busy;
    take_svc = SVC_REQ_IN && !REG_WR_IN && !REG_RD_IN && !sack_ff && !busy;
    wr_go = take_reg || take_svc; // R13
    wa = take_reg ? REG_ADDR_IN : SVC_ADDR_IN;
    wd = take_reg ? REG_WDATA_IN : SVC_DATA_IN;
    // Decoded once; a function result cannot be sliced directly
    wkind = map_kind(wa);
    xhdr = wkind[7:0];
    send = wr_go && wkind[8];
    xdata = {xhdr, wd};
  end

  // Register file next values
  always_comb begin
    nxt_guard = guard_ff;
    nxt_port = port_ff;
    nxt_len = len_ff;
    nxt_grp = grp_ff;
    nxt_slot = slot_ff;
    nxt_sub = sub_ff;
    if (wr_go) begin
      if (wa == tsm_pkg::OFS_GUARD) nxt_guard = wd;
      if (wa == tsm_pkg::OFS_PORT) nxt_port = wd;
      if (wa == tsm_pkg::OFS_LEN) nxt_len = wd; // R05
      if (wa == tsm_pkg::OFS_GRP) nxt_grp = wd;
      if (wkind[7:6] == tsm_pkg::K_SLOT && wkind[8])
        nxt_slot[wa[4:2]] = wd;
      if (wkind[7:6] == tsm_pkg::K_SUB && wkind[8])
        nxt_sub[wa[7:2]] = wd;
    end
  end
  always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      guard_ff <= tsm_pkg::RST_WORD;
      port_ff <= tsm_pkg::RST_WORD;
      len_ff <= tsm_pkg::RST_WORD;
      grp_ff <= tsm_pkg::RST_WORD;
      slot_ff <= '{default: tsm_pkg::RST_WORD};
      sub_ff <= '{default: tsm_pkg::RST_WORD};
    end else begin
      guard_ff <= nxt_guard;
      port_ff <= nxt_port;
      len_ff <= nxt_len;
      grp_ff <= nxt_grp;
      slot_ff <= nxt_slot;
      sub_ff <= nxt_sub;
    end
  end

  // Read data and acknowledges; unmapped reads return zero
  always_comb begin
    nxt_rdata = rdata_ff;
    nxt_ack = take_rd || take_reg;
    nxt_sack = take_svc;
    if (take_rd) begin
      unique case (REG_ADDR_IN[9:8])
        tsm_pkg::ADDR_PAGE_SLOT:
          nxt_rdata = (REG_ADDR_IN[7:2] < 6'(tsm_pkg::SLOT_WORDS)) ?
                      slot_ff[REG_ADDR_IN[4:2]] : tsm_pkg::RST_WORD;
        tsm_pkg::ADDR_PAGE_SUB: nxt_rdata = sub_ff[REG_ADDR_IN[7:2]];
        default: begin
          nxt_rdata = tsm_pkg::RST_WORD;
          if (REG_ADDR_IN == tsm_pkg::OFS_GUARD) nxt_rdata = guard_ff;
          if (REG_ADDR_IN == tsm_pkg::OFS_PORT) nxt_rdata = port_ff;
          if (REG_ADDR_IN == tsm_pkg::OFS_LEN) nxt_rdata = len_ff;
          if (REG_ADDR_IN == tsm_pkg::OFS_GRP) nxt_rdata = grp_ff;
          if (REG_ADDR_IN == tsm_pkg::OFS_STAT) begin
            nxt_rdata[tsm_pkg::ST_BUSY] = busy;
            nxt_rdata[tsm_pkg::ST_LOSS] = link_loss;
          end
        end
      endcase
    end
  end

  // Length check against the selected limit; protection fault gate
  assign lim_a = len_ff[tsm_pkg::LIM_A_LO +: tsm_pkg::LIM_W];
  assign lim_b = len_ff[tsm_pkg::LIM_B_LO +: tsm_pkg::LIM_W];
  always_comb begin
    nxt_long = 1'b0;
    if (MSG_CHECK_IN && MSG_SEL_IN == tsm_pkg::SEL_A) // R05
      nxt_long = MSG_LEN_IN > lim_a;
    else if (MSG_CHECK_IN && MSG_SEL_IN == tsm_pkg::SEL_B)
      nxt_long = MSG_LEN_IN > lim_b;
    // With the guard off no fault is ever raised
    nxt_fault = guard_ff[tsm_pkg::GUARD_BIT] && DMA_OOB_IN; // R01
  end
  always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      rdata_ff <= tsm_pkg::RST_WORD;
      ack_ff <= 1'b0;
      sack_ff <= 1'b0;
      long_ff <= 1'b0;
      fault_ff <= 1'b0;
      loss1_ff <= 1'b0;
      loss2_ff <= 1'b0;
    end else begin
      rdata_ff <= nxt_rdata;
      ack_ff <= nxt_ack;
      sack_ff <= nxt_sack;
      long_ff <= nxt_long;
      fault_ff <= nxt_fault;
      loss1_ff <= RX_LOSS_OUT;
      loss2_ff <= loss1_ff;
    end
  end
  assign link_loss = loss2_ff;
  assign REG_RDATA_OUT = rdata_ff;
  assign REG_ACK_OUT = ack_ff;
  assign SVC_ACK_OUT = sack_ff;
  assign MSG_TOO_LONG_OUT = long_ff;
  assign PROT_FAULT_OUT = fault_ff;

  // Every mirrored write is carried word by word to the link side;
  // the handshake is slow but keeps each word whole across the boundary
  tsm_cdc_word u_cdc (
    .clk_a_in(CLK_SYS_IN),
    .rst_a_n_in(RESET_N_IN),
    .send_in(send),
    .data_in(xdata),
    .busy_out(busy),
    .clk_b_in(CLK_LINK_IN),
    .rst_b_n_in(RESET_N_IN),
    .upd_out(upd),
    .data_out(upd_data)
  );

  tsm_link_port u_link (
    .clk_link_in(CLK_LINK_IN),
    .rst_n_in(RESET_N_IN),
    .upd_in(upd),
    .upd_data_in(upd_data),
    .tx_sync_in(TX_SYNC_IN),
    .rx_sync_in(RX_SYNC_IN),
    .rx_data_in(RX_DATA_IN),
    .rx_loss_in(RX_LOSS_IN),
    .tx_chan_bit_in(TX_CHAN_BIT_IN),
    .tx_data_out(TX_DATA_OUT),
    .tx_data_oe_out(TX_DATA_OE_OUT),
    .tx_req_out(TX_REQ_OUT),
    .tx_chan_out(TX_CHAN_OUT),
    .rx_bit_out(RX_BIT_OUT),
    .rx_valid_out(RX_VALID_OUT),
    .rx_chan_out(RX_CHAN_OUT),
    .rx_loss_out(RX_LOSS_OUT)
  );

  sequence svc_taken_s;
    SVC_REQ_IN && !REG_WR_IN && !REG_RD_IN && !sack_ff && !busy;
  endsequence
  sequence svc_done_s;
    ##1 SVC_ACK_OUT ##1 !SVC_ACK_OUT;
  endsequence

  guard_off_a: assert property (@(posedge CLK_SYS_IN) disable iff (!RESET_N_IN) // R01
    !guard_ff[tsm_pkg::GUARD_BIT] |=> !PROT_FAULT_OUT)
    else $error("fault raised with guard off");
  limit_a_a: assert property (@(posedge CLK_SYS_IN) disable iff (!RESET_N_IN) // R05
    MSG_CHECK_IN && MSG_SEL_IN == tsm_pkg::SEL_A
    |=> MSG_TOO_LONG_OUT == ($past(MSG_LEN_IN) > $past(lim_a)))
    else $error("length limit a misjudged");
  svc_path_a: assert property (@(posedge CLK_SYS_IN) disable iff (!RESET_N_IN) // R13
    svc_taken_s |-> svc_done_s) else $error("service request not acknowledged");
  slot_store_a: assert property (@(posedge CLK_SYS_IN) disable iff (!RESET_N_IN) // R06
    REG_WR_IN && !ack_ff && !busy && REG_ADDR_IN == tsm_pkg::OFS_SLOT
    |=> slot_ff[0] == $past(REG_WDATA_IN) && busy)
    else $error("slot word not stored or not sent");
  busy_hold_a: assert property (@(posedge CLK_SYS_IN) disable iff (!RESET_N_IN) // R13
    busy |-> !($past(busy) && REG_ACK_OUT && $past(REG_WR_IN, 1) && !$past(REG_RD_IN)))
    else $error("write taken while link busy");
endmodule // tsm_cfg_top
`default_nettype wire

// ===== tb/tsm_framer_model.sv
// Framer model: frame sync pulses, receive data and frame-loss level.
// Assumes a free-running link clock from the bench, as the link side expects.
`timescale 1ns/10ps
`default_nettype none
module tsm_framer_model #(
  parameter int FRAME_BITS = 256
) (
  input wire logic clk_link_in,
  input wire logic rst_n_in,
  input wire logic loss_in,
  output logic sync_out,
  output logic data_out,
  output logic loss_out
);
  logic [8:0] bit_ff;
  logic [8:0] nxt_bit;
  // Bit counter wraps at the frame length so that sync marks bit 0
  always_comb begin
    nxt_bit = (bit_ff == 9'(FRAME_BITS - 1)) ? 9'h000 : bit_ff + 9'h001;
  end
  always_ff @(posedge clk_link_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      bit_ff <= 9'h000;
    end else begin
      bit_ff <= nxt_bit;
    end
  end
  // Changes after the rising edge, so either sampling edge sees it settled
  assign sync_out = (bit_ff == 9'h000);
  assign data_out = bit_ff[0] ^ bit_ff[3]; // Keeps toggling, never parks
  assign loss_out = loss_in;
endmodule // tsm_framer_model
`default_nettype wire

// ===== tb/tsm_cfg_top_bench.sv
// Bench for the slot mapping block: register and service access, limits,
// guard and per-frame slot counts. Assumes the framer model beside it.
`timescale 1ns/10ps
`default_nettype none
module tsm_cfg_top_bench;
  logic CLK_SYS_IN = 0, CLK_LINK_IN = 0, RESET_N_IN = 0;
  logic REG_WR_IN = 0, REG_RD_IN = 0, SVC_REQ_IN = 0, MSG_CHECK_IN = 0;
  logic [9:0] REG_ADDR_IN = 10'h000, SVC_ADDR_IN = 10'h000;
  logic [31:0] REG_WDATA_IN = 32'h0, SVC_DATA_IN = 32'h0, REG_RDATA_OUT, q;
  logic REG_ACK_OUT, SVC_ACK_OUT, MSG_TOO_LONG_OUT, PROT_FAULT_OUT;
  logic [1:0] MSG_SEL_IN = 2'h0;
  logic [13:0] MSG_LEN_IN = 14'h0000;
  logic DMA_OOB_IN = 0, TX_CHAN_BIT_IN = 0, loss = 0, sync, rxd, rxl;
  logic TX_DATA_OUT, TX_DATA_OE_OUT, TX_REQ_OUT, RX_BIT_OUT, RX_VALID_OUT, RX_LOSS_OUT;
  logic [4:0] TX_CHAN_OUT, RX_CHAN_OUT;
  int mismatches = 0, compares = 0, req_n, oe_n, rxv_n, one_n, rxo_n, rx2_n;
  int cnt [32];
  always #12.5 CLK_SYS_IN = ~CLK_SYS_IN;
  always #3 CLK_LINK_IN = ~CLK_LINK_IN;
  tsm_cfg_top u_dut (.CLK_SYS_IN(CLK_SYS_IN), .RESET_N_IN(RESET_N_IN),
    .REG_WR_IN(REG_WR_IN), .REG_RD_IN(REG_RD_IN), .REG_ADDR_IN(REG_ADDR_IN),
    .REG_WDATA_IN(REG_WDATA_IN), .REG_RDATA_OUT(REG_RDATA_OUT), .REG_ACK_OUT(REG_ACK_OUT),
    .SVC_REQ_IN(SVC_REQ_IN), .SVC_ADDR_IN(SVC_ADDR_IN), .SVC_DATA_IN(SVC_DATA_IN),
    .SVC_ACK_OUT(SVC_ACK_OUT), .MSG_CHECK_IN(MSG_CHECK_IN), .MSG_SEL_IN(MSG_SEL_IN),
    .MSG_LEN_IN(MSG_LEN_IN), .MSG_TOO_LONG_OUT(MSG_TOO_LONG_OUT), .DMA_OOB_IN(DMA_OOB_IN),
    .PROT_FAULT_OUT(PROT_FAULT_OUT), .CLK_LINK_IN(CLK_LINK_IN), .TX_SYNC_IN(sync),
    .RX_SYNC_IN(sync), .RX_DATA_IN(rxd), .RX_LOSS_IN(rxl), .TX_CHAN_BIT_IN(TX_CHAN_BIT_IN),
    .TX_DATA_OUT(TX_DATA_OUT), .TX_DATA_OE_OUT(TX_DATA_OE_OUT), .TX_REQ_OUT(TX_REQ_OUT),
    .TX_CHAN_OUT(TX_CHAN_OUT), .RX_BIT_OUT(RX_BIT_OUT), .RX_VALID_OUT(RX_VALID_OUT),
    .RX_CHAN_OUT(RX_CHAN_OUT), .RX_LOSS_OUT(RX_LOSS_OUT));
  tsm_framer_model u_framer (.clk_link_in(CLK_LINK_IN), .rst_n_in(RESET_N_IN),
    .loss_in(loss), .sync_out(sync), .data_out(rxd), .loss_out(rxl));
  // One comparison, counted; mismatches reported at once
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Access: kind 0 read, 1 direct write, 2 service request; held until acked
  task automatic acc(input int kind, input logic [9:0] a, input logic [31:0] d);
    int n;
    n = 0;
    REG_ADDR_IN = a;
    SVC_ADDR_IN = a;
    REG_WDATA_IN = d;
    SVC_DATA_IN = d;
    REG_RD_IN = (kind == 0);
    REG_WR_IN = (kind == 1);
    SVC_REQ_IN = (kind == 2);
    do begin
      @(negedge CLK_SYS_IN);
      n++;
    end while ((kind == 2 ? SVC_ACK_OUT : REG_ACK_OUT) !== 1'b1 && n < 100);
    q = REG_RDATA_OUT;
    if (n >= 100) chk("ack", 32'h0, 32'h1);
    @(posedge CLK_SYS_IN);
    #1;
    REG_RD_IN = 0;
    REG_WR_IN = 0;
    SVC_REQ_IN = 0;
    // Idle cycle so the next call never re-drives a strobe in this step
    @(posedge CLK_SYS_IN);
    #1;
  endtask
  task automatic lim(input logic [1:0] s, input logic [13:0] l, input logic e);
    MSG_SEL_IN = s;
    MSG_LEN_IN = l;
    MSG_CHECK_IN = 1;
    @(posedge CLK_SYS_IN);
    #1;
    MSG_CHECK_IN = 0;
    chk("too_long", 32'(MSG_TOO_LONG_OUT), 32'(e));
    @(posedge CLK_SYS_IN);
    #1;
  endtask
  // Settle a config change, then count link outputs over one whole frame
  task automatic measure();
    cnt = '{default: 0};
    {req_n, oe_n, rxv_n, one_n, rxo_n, rx2_n} = 192'h0;
    repeat (200) @(posedge CLK_SYS_IN);
    repeat (256) begin
      @(posedge CLK_LINK_IN);
      #1;
      if (TX_REQ_OUT === 1'b1) begin
        req_n++;
        cnt[TX_CHAN_OUT]++;
      end
      if (TX_DATA_OE_OUT === 1'b1) oe_n++;
      if (TX_DATA_OE_OUT === 1'b1 && TX_DATA_OUT === 1'b1) one_n++;
      if (RX_VALID_OUT === 1'b1) rxv_n++;
      if (RX_VALID_OUT === 1'b1 && RX_BIT_OUT === 1'b1) rxo_n++;
      if (RX_VALID_OUT === 1'b1 && RX_CHAN_OUT === 5'h02) rx2_n++;
    end
  endtask
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Whole run is near 30 us; cut off well beyond that
  initial begin
    #500000;
    mismatches++;
    wrap_up();
  end
  initial begin
    logic [9:0] ad [7];
    logic [31:0] dv [7];
    ad = '{10'h000, 10'h004, 10'h008, 10'h00C, 10'h100, 10'h208, 10'h20C};
    dv = '{32'h1, 32'h1, 32'h0200_0400, 32'h0, 32'h8282_E180, 32'h8181_8100, 32'h0};
    repeat (8) @(posedge CLK_SYS_IN);
    #1;
    RESET_N_IN = 1;
    // Reset values, status included, all zero
    foreach (ad[i]) begin
      acc(0, ad[i], 32'h0);
      chk("reset", q, 32'h0);
    end
    acc(0, 10'h010, 32'h0);
    chk("status", q, 32'h0);
    // Unmapped place ignores writes and reads zero
    acc(1, 10'h3F0, 32'hFFFF_FFFF);
    acc(0, 10'h3F0, 32'h0);
    chk("unmapped", q, 32'h0);
    // Alternate the two load paths, then read every word back
    foreach (ad[i]) acc(i % 2 + 1, ad[i], dv[i]);
    foreach (ad[i]) begin
      acc(0, ad[i], 32'h0);
      chk("readback", q, dv[i]);
    end
    lim(2'h1, 14'h0400, 1'b0);
    lim(2'h1, 14'h0401, 1'b1);
    lim(2'h2, 14'h0200, 1'b0);
    lim(2'h2, 14'h0201, 1'b1);
    lim(2'h0, 14'h3FFF, 1'b0);
    lim(2'h3, 14'h3FFF, 1'b0);
    DMA_OOB_IN = 1;
    @(posedge CLK_SYS_IN);
    #1;
    chk("fault_on", 32'(PROT_FAULT_OUT), 32'h1);
    acc(1, 10'h000, 32'h0);
    @(posedge CLK_SYS_IN);
    #1;
    chk("fault_off", 32'(PROT_FAULT_OUT), 32'h0);
    DMA_OOB_IN = 0;
    // E1 frame, falling edges: ch0 whole slot, ch1 bits 0..3, ch2 two slots
    acc(2, 10'h00C, 32'h1);
    loss = 1;
    TX_CHAN_BIT_IN = 1;
    measure();
    TX_CHAN_BIT_IN = 0;
    chk("ones_ch", 32'(one_n), 32'h1C);
    // Framer data is bit0 xor bit3 of the frame bit number
    chk("rx_ones", 32'(rxo_n), 32'hE);
    chk("rx_ch2", 32'(rx2_n), 32'h10);
    chk("ch0", 32'(cnt[0]), 32'h8);
    chk("ch1", 32'(cnt[1]), 32'h4);
    chk("ch2", 32'(cnt[2]), 32'h10);
    chk("req", 32'(req_n), 32'h1C);
    chk("oe", 32'(oe_n), 32'h1C);
    chk("rxv", 32'(rxv_n), 32'h1C);
    chk("loss", 32'(RX_LOSS_OUT), 32'h1);
    acc(0, 10'h010, 32'h0);
    chk("status", q, 32'h2);
    loss = 0;
    // Bit slicing off makes the code 7 slot whole
    acc(1, 10'h00C, 32'h3);
    measure();
    chk("ch1_whole", 32'(cnt[1]), 32'h8);
    // Rising edges and driven unmapped slots: ones outside the 32 mapped bits
    acc(2, 10'h004, 32'h011F_0001);
    measure();
    chk("req_rise", 32'(req_n), 32'h20);
    chk("oe_all", 32'(oe_n), 32'h100);
    chk("ones", 32'(one_n), 32'hE0);
    // Transmitter off floats the pin and requests nothing
    acc(1, 10'h00C, 32'h0);
    measure();
    chk("oe_off", 32'(oe_n), 32'h0);
    chk("req_off", 32'(req_n), 32'h0);
    wrap_up();
  end
endmodule // tsm_cfg_top_bench
`default_nettype wire
